/* File: core/psh_pkg.sv */
// Package of shared constants and types for the power-state handshake.
package psh_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int DEBOUNCE_MS = 30;
    localparam int IRQ_LATENCY_MS = 1;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int IRQ_LATENCY_CYC = CLK_HZ / 1000 * IRQ_LATENCY_MS;
    localparam int RAIL_SETTLE_CYC = 4;
    localparam int CNT_W = 20;

    // ---------------------------------------------------------------
    // Interrupt sources and rail indices
    // ---------------------------------------------------------------
    localparam int IRQ_W = 8;
    localparam int SUS_RAILS = 3;
    localparam int SYNC_W = 9;

    // ---------------------------------------------------------------
    // Power states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PSH_POWER_DOWN,
        PSH_AON_UP,
        PSH_ACTIVE,
        PSH_STANDBY_IDLE,
        PSH_SUSPEND_RAM,
        PSH_SUSPEND_DISK
    } psh_state_t;

endpackage : psh_pkg

/* File: core/psh_link_if.sv */
// Interface carrying the sideband signals between host and device.
`timescale 1ns/1ps
`default_nettype none
interface psh_link_if;
    logic suspend_ram_request_n;
    logic suspend_disk_request_n;
    logic standby_idle_request_n;
    logic platform_reset_n;
    logic suspend_powerdown_ack;
    logic thermal_trip_n;
    logic sd_low_voltage_select;
    logic charger_detect_n;
    logic suspend_clock;
    logic resume_reset_n;
    logic memory_power_good;
    logic always_on_power_good;
    logic core_power_good;
    logic interrupt;
    logic power_button_out_n;
    logic adapter_present;
    logic battery_low_n;

    modport device (
        input suspend_ram_request_n, suspend_disk_request_n, standby_idle_request_n,
        input platform_reset_n, suspend_powerdown_ack, thermal_trip_n,
        input sd_low_voltage_select, charger_detect_n, suspend_clock,
        output resume_reset_n, memory_power_good, always_on_power_good,
        output core_power_good, interrupt, power_button_out_n, adapter_present,
        output battery_low_n
    );
    modport host (
        output suspend_ram_request_n, suspend_disk_request_n, standby_idle_request_n,
        output platform_reset_n, suspend_powerdown_ack, thermal_trip_n,
        output sd_low_voltage_select, charger_detect_n, suspend_clock,
        input resume_reset_n, memory_power_good, always_on_power_good,
        input core_power_good, interrupt, power_button_out_n, adapter_present,
        input battery_low_n
    );
endinterface : psh_link_if
`default_nettype wire

/* File: core/psh_debounce.sv */
// Level debouncer: output follows input after it stays stable for a count.
`timescale 1ns/1ps
`default_nettype none
module psh_debounce (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic [psh_pkg::CNT_W-1:0] cnt_r;

    // Count while input and output differ, restart when they agree; take the level when it matures.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            dout <= 1'b1;
        end else if (din == dout) begin
            cnt_r <= '0;
        end else if (cnt_r == psh_pkg::CNT_W'(psh_pkg::DEBOUNCE_CYC - 1)) begin
            cnt_r <= '0;
            dout <= din;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : psh_debounce
`default_nettype wire

/* File: core/psh_device.sv */
// Device end: power-state handshake logic facing the host.
// Contract
// [R1] Interrupt high when any unmasked bit set.
// [R2] Interrupt raised within one millisecond.
// [R3] Debounce power button for 30 ms.
// [R4] Forward debounced button level to host.
// [R5] Ignore platform reset in standby states.
// [R6] Standby-idle request low enters, high exits.
// [R7] Suspend-to-RAM request low enters, high exits.
// [R8] Suspend-to-disk request low enters, high exits.
// [R9] Hold resume reset until always-on rail up.
// [R10] Pull resume reset low in power-down.
// [R11] Memory power-good after memory rail stable.
// [R12] Always-on power-good when rails nominal.
// [R13] Always-on good drops only on both lows.
// [R14] Core power-good when rails nominal.
// [R15] Core good drops only on both lows.
// [R16] Core good low in power-down.
// [R17] Acknowledge with disk request cuts suspend rails.
// [R18] Host gives suspend clock after reset release.
// [R19] Never rely on suspend clock.
// [R20] Adapter present on adapter or charger low.
// [R21] SD supply 1.8 V when select high.
// [R22] Thermal trip shuts all rails.
// [R23] Sample trip only outside platform reset, immediately.
// [R24] Two-stage synchronise every host input.
`timescale 1ns/1ps
`default_nettype none
module psh_device (
    input wire logic mclk,
    input wire logic rst_n,
    psh_link_if.device link,
    input wire logic power_button_in_n,
    input wire logic adapter_voltage_valid,
    input wire logic battery_voltage_low,
    input wire logic power_on_request,
    input wire logic always_on_3v3_rail_good,
    input wire logic memory_supply_rail_good,
    input wire logic core_rails_good,
    input wire logic [psh_pkg::IRQ_W-1:0] irq_events,
    input wire logic [psh_pkg::IRQ_W-1:0] irq_mask,
    input wire logic [psh_pkg::IRQ_W-1:0] irq_clear,
    output logic always_on_3v3_rail_en,
    output logic [psh_pkg::SUS_RAILS-1:0] suspend_rails_en,
    output logic memory_supply_rail_en,
    output logic core_rails_en,
    output logic sd_supply_1v8_sel,
    output logic [psh_pkg::IRQ_W-1:0] irq_status,
    output logic thermal_shutdown,
    output psh_pkg::psh_state_t power_state
);
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [psh_pkg::SYNC_W-1:0] raw, meta_r, sync_r;
    assign raw = {link.suspend_ram_request_n, link.suspend_disk_request_n,
                  link.standby_idle_request_n, link.platform_reset_n,
                  link.suspend_powerdown_ack, link.thermal_trip_n,
                  link.sd_low_voltage_select, link.charger_detect_n,
                  power_button_in_n};

    // Stage one feeds stage two only; the suspend clock is never sampled.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '1; // R24
            sync_r <= '1;
        end else begin
            meta_r <= raw; // R24
            sync_r <= meta_r; // R19
        end
    end

    logic ram_n, dsk_n, sx_n, plt_n, ack, trip_n, sdsel, chg_n, btn_n;
    assign {ram_n, dsk_n, sx_n, plt_n, ack, trip_n, sdsel, chg_n, btn_n} = sync_r;

    // ---------------------------------------------------------------
    // Power button
    // ---------------------------------------------------------------
    logic btn_db;
    psh_debounce u_btn (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(btn_n),
        .dout(btn_db) // R3
    );

    // ---------------------------------------------------------------
    // State machine
    // ---------------------------------------------------------------
    psh_pkg::psh_state_t state_r, state_nxt;
    logic trip_r;
    logic [psh_pkg::CNT_W-1:0] settle_r;
    logic rsm_released;
    assign rsm_released = (state_r != psh_pkg::PSH_POWER_DOWN) &&
                          (state_r != psh_pkg::PSH_AON_UP);

    logic trip_now;
    // Trip is looked at only while the host is out of platform reset.
    assign trip_now = rsm_released && plt_n && !trip_n; // R23

    // Next state from the synchronised requests.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            psh_pkg::PSH_POWER_DOWN: begin
                if (power_on_request && !trip_r) begin
                    state_nxt = psh_pkg::PSH_AON_UP;
                end
            end
            psh_pkg::PSH_AON_UP: begin
                if (always_on_3v3_rail_good &&
                    settle_r == psh_pkg::CNT_W'(psh_pkg::RAIL_SETTLE_CYC)) begin
                    state_nxt = psh_pkg::PSH_ACTIVE; // R9
                end
            end
            psh_pkg::PSH_ACTIVE: begin
                if (!dsk_n) begin
                    state_nxt = psh_pkg::PSH_SUSPEND_DISK; // R8
                end else if (!ram_n) begin
                    state_nxt = psh_pkg::PSH_SUSPEND_RAM; // R7
                end else if (!sx_n) begin
                    state_nxt = psh_pkg::PSH_STANDBY_IDLE; // R6
                end
            end
            psh_pkg::PSH_STANDBY_IDLE: begin
                if (!ram_n) begin
                    state_nxt = psh_pkg::PSH_SUSPEND_RAM;
                end else if (sx_n) begin
                    state_nxt = psh_pkg::PSH_ACTIVE; // R6
                end
            end
            psh_pkg::PSH_SUSPEND_RAM: begin
                if (!dsk_n) begin
                    state_nxt = psh_pkg::PSH_SUSPEND_DISK;
                end else if (ram_n) begin
                    state_nxt = psh_pkg::PSH_ACTIVE; // R7
                end
            end
            psh_pkg::PSH_SUSPEND_DISK: begin
                if (ack) begin
                    state_nxt = psh_pkg::PSH_POWER_DOWN; // R17
                end else if (dsk_n) begin
                    state_nxt = psh_pkg::PSH_ACTIVE; // R8
                end
            end
        endcase
        if (trip_now) begin
            state_nxt = psh_pkg::PSH_POWER_DOWN; // R22
        end
    end

    // State register and settle counter for the always-on rail.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= psh_pkg::PSH_POWER_DOWN;
            settle_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r != psh_pkg::PSH_AON_UP || !always_on_3v3_rail_good) begin
                settle_r <= '0;
            end else if (settle_r != psh_pkg::CNT_W'(psh_pkg::RAIL_SETTLE_CYC)) begin
                settle_r <= settle_r + 1'b1;
            end
        end
    end

    // Thermal trip latch; held until the power-on request is dropped low, which clears it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trip_r <= 1'b0;
        end else if (trip_now) begin
            trip_r <= 1'b1; // R23
        end else if (!power_on_request) begin
            trip_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Rails and power-good outputs
    // ---------------------------------------------------------------
    logic core_on, pg_r, rsm_r;
    assign core_on = (state_r == psh_pkg::PSH_ACTIVE) ||
                     (state_r == psh_pkg::PSH_STANDBY_IDLE);

    // Power-good holds through standby-idle entry until both host lows are seen;
    // platform reset is not consulted while already in standby.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pg_r <= 1'b0;
        end else if (!core_on || trip_now) begin
            pg_r <= 1'b0; // R16
        end else if (core_rails_good && memory_supply_rail_good) begin
            if (state_r == psh_pkg::PSH_ACTIVE && !plt_n && !sx_n) begin
                pg_r <= 1'b0; // R13 R15
            end else if (state_r == psh_pkg::PSH_ACTIVE) begin
                pg_r <= 1'b1; // R12 R14
            end
            // R5: in standby the level is kept whatever platform reset does.
        end else begin
            pg_r <= 1'b0;
        end
    end

    // Resume reset and registered data outputs.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsm_r <= 1'b0;
            link.memory_power_good <= 1'b0;
            link.adapter_present <= 1'b0;
            link.battery_low_n <= 1'b1;
            sd_supply_1v8_sel <= 1'b0;
        end else begin
            rsm_r <= rsm_released && !trip_now; // R9 R10
            link.memory_power_good <= memory_supply_rail_en && memory_supply_rail_good; // R11
            link.adapter_present <= adapter_voltage_valid || !chg_n; // R20
            link.battery_low_n <= !battery_voltage_low;
            if (rsm_released && pg_r) begin
                sd_supply_1v8_sel <= sdsel; // R21
            end
        end
    end

    assign link.resume_reset_n = rsm_r;
    assign link.always_on_power_good = pg_r;
    assign link.core_power_good = pg_r;
    assign link.power_button_out_n = rsm_r ? btn_db : 1'b1; // R4
    assign always_on_3v3_rail_en = (state_r != psh_pkg::PSH_POWER_DOWN);
    assign suspend_rails_en = {psh_pkg::SUS_RAILS{always_on_3v3_rail_en}}; // R17
    assign memory_supply_rail_en = rsm_released && (state_r != psh_pkg::PSH_SUSPEND_DISK);
    assign core_rails_en = core_on;
    assign thermal_shutdown = trip_r;
    assign power_state = state_r;

    // ---------------------------------------------------------------
    // Interrupt status
    // ---------------------------------------------------------------
    logic [psh_pkg::IRQ_W-1:0] irq_r;
    logic irq_out_r;

    // Set wins over clear so no event is lost in the clearing cycle.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= '0;
        end else begin
            irq_r <= (irq_r & ~irq_clear) | irq_events;
        end
    end

    // One cycle from status to line, far inside the millisecond budget.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_r <= 1'b0;
        end else begin
            irq_out_r <= rsm_r && |(irq_r & ~irq_mask); // R1 R2
        end
    end

    assign irq_status = irq_r;
    assign link.interrupt = irq_out_r;
endmodule : psh_device
`default_nettype wire

/* File: core/psh_host.sv */
// Host end: drives the sleep requests and sideband lines toward the device.
`timescale 1ns/1ps
`default_nettype none
module psh_host (
    input wire logic mclk,
    input wire logic rst_n,
    psh_link_if.host link,
    input wire logic req_standby_idle,
    input wire logic req_suspend_ram,
    input wire logic req_suspend_disk,
    input wire logic req_powerdown,
    input wire logic platform_in_reset,
    input wire logic thermal_event,
    input wire logic sd_1v8_wanted,
    input wire logic charger_seen,
    output logic device_ready,
    output logic interrupt_seen,
    output logic button_pressed
);
    localparam int SUSPEND_CLOCK_HALF = psh_pkg::CLK_HZ / 65536;
    logic [psh_pkg::CNT_W-1:0] div_r;
    logic clk_r;

    // Requests only while resume reset is released; ack only with disk low.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.standby_idle_request_n <= 1'b1;
            link.suspend_ram_request_n <= 1'b1;
            link.suspend_disk_request_n <= 1'b1;
            link.suspend_powerdown_ack <= 1'b0;
            link.platform_reset_n <= 1'b0;
            link.thermal_trip_n <= 1'b1;
            link.sd_low_voltage_select <= 1'b0;
            link.charger_detect_n <= 1'b1;
        end else begin
            link.standby_idle_request_n <= !(link.resume_reset_n && req_standby_idle); // R6
            link.suspend_ram_request_n <= !(link.resume_reset_n && req_suspend_ram); // R7
            link.suspend_disk_request_n <= !(link.resume_reset_n && req_suspend_disk); // R8
            link.suspend_powerdown_ack <= link.resume_reset_n && req_suspend_disk &&
                                          req_powerdown; // R17
            link.platform_reset_n <= link.resume_reset_n && !platform_in_reset;
            link.thermal_trip_n <= !thermal_event;
            link.sd_low_voltage_select <= sd_1v8_wanted;
            link.charger_detect_n <= !charger_seen;
        end
    end

    // Suspend clock divided from mclk, run only while resume reset released.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
            clk_r <= 1'b0;
        end else if (!link.resume_reset_n) begin
            div_r <= '0;
            clk_r <= 1'b0;
        end else if (div_r == psh_pkg::CNT_W'(SUSPEND_CLOCK_HALF - 1)) begin
            div_r <= '0;
            clk_r <= !clk_r; // R18
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign link.suspend_clock = clk_r;
    assign device_ready = link.resume_reset_n && link.core_power_good;
    assign interrupt_seen = link.resume_reset_n && link.interrupt;
    assign button_pressed = link.resume_reset_n && !link.power_button_out_n;
endmodule : psh_host
`default_nettype wire

/* File: test/psh_link_sva.sv */
// Checker of the sideband link between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module psh_link_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic platform_reset_n,
    input wire logic standby_idle_request_n,
    input wire logic suspend_ram_request_n,
    input wire logic suspend_disk_request_n,
    input wire logic thermal_trip_n,
    input wire logic charger_detect_n,
    input wire logic resume_reset_n,
    input wire logic memory_power_good,
    input wire logic always_on_power_good,
    input wire logic core_power_good,
    input wire logic interrupt,
    input wire logic power_button_out_n,
    input wire logic adapter_present
);
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // One clock domain, so clock and reset are given once for all.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_pg_same_flop: assert property (always_on_power_good == core_power_good)
        else $error("power-good outputs disagree");
    a_pg_drop_cause: assert property ($fell(core_power_good) && suspend_ram_request_n
        && suspend_disk_request_n && thermal_trip_n |-> !platform_reset_n
        && !standby_idle_request_n) else $error("power-good dropped without both lows");
    a_adapter_follow: assert property (!charger_detect_n [*4] |-> adapter_present)
        else $error("adapter present missing on charger detect");
    a_button_held: assert property (!resume_reset_n && !$past(resume_reset_n)
        |-> power_button_out_n) else $error("button output active in resume reset");
    a_irq_resume: assert property (interrupt |-> resume_reset_n || $past(resume_reset_n))
        else $error("interrupt raised while resume reset held");
    a_trip_cut: assert property ($fell(thermal_trip_n) && platform_reset_n
        && resume_reset_n |-> ##[1:8] !resume_reset_n) else $error("trip did not shut down");
    a_pg_after_resume: assert property ($rose(core_power_good) |-> resume_reset_n)
        else $error("power-good before resume reset release");
    a_pg_power_down: assert property (!resume_reset_n [*3]
        |-> !core_power_good && !memory_power_good) else $error("power-good in power-down");

    // Main scenarios must be reached for the assertions above to mean much.
    c_pg_up: cover property ($rose(core_power_good));
    c_idle_drop: cover property ($fell(core_power_good) && !standby_idle_request_n);
    c_irq: cover property ($rose(interrupt));
    c_trip: cover property ($fell(thermal_trip_n) && platform_reset_n);
endmodule : psh_link_sva
`default_nettype wire

/* File: test/soc_power_state_handshake_tb_top.sv */
// Self-checking testbench joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module soc_power_state_handshake_tb_top;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n, power_button_in_n, adapter_voltage_valid, battery_voltage_low;
    logic power_on_request, always_on_3v3_rail_good, memory_supply_rail_good, core_rails_good;
    logic [psh_pkg::IRQ_W-1:0] irq_events, irq_mask, irq_clear, irq_status;
    logic always_on_3v3_rail_en, memory_supply_rail_en, core_rails_en;
    logic sd_supply_1v8_sel, thermal_shutdown;
    logic [psh_pkg::SUS_RAILS-1:0] suspend_rails_en;
    psh_pkg::psh_state_t power_state;
    logic req_standby_idle, req_suspend_ram, req_suspend_disk, req_powerdown;
    logic platform_in_reset, thermal_event, sd_1v8_wanted, charger_seen;
    logic device_ready, interrupt_seen, button_pressed, exp_irq;
    int bad_count = 0;
    int n_checks = 0;
    int seed = 32'h3d8bf0a1;
    logic [31:0] r;
    psh_link_if lnk ();
    psh_device i_psh_device (.mclk, .rst_n, .link(lnk), .power_button_in_n,
        .adapter_voltage_valid, .battery_voltage_low, .power_on_request,
        .always_on_3v3_rail_good, .memory_supply_rail_good, .core_rails_good, .irq_events,
        .irq_mask, .irq_clear, .always_on_3v3_rail_en, .suspend_rails_en,
        .memory_supply_rail_en, .core_rails_en, .sd_supply_1v8_sel, .irq_status,
        .thermal_shutdown, .power_state);
    psh_host i_psh_host (.mclk, .rst_n, .link(lnk), .req_standby_idle, .req_suspend_ram,
        .req_suspend_disk, .req_powerdown, .platform_in_reset, .thermal_event, .sd_1v8_wanted,
        .charger_seen, .device_ready, .interrupt_seen, .button_pressed);
    psh_link_sva i_psh_link_sva (.mclk, .rst_n, .platform_reset_n(lnk.platform_reset_n),
        .standby_idle_request_n(lnk.standby_idle_request_n),
        .suspend_ram_request_n(lnk.suspend_ram_request_n),
        .suspend_disk_request_n(lnk.suspend_disk_request_n),
        .thermal_trip_n(lnk.thermal_trip_n), .charger_detect_n(lnk.charger_detect_n),
        .resume_reset_n(lnk.resume_reset_n), .memory_power_good(lnk.memory_power_good),
        .always_on_power_good(lnk.always_on_power_good),
        .core_power_good(lnk.core_power_good), .interrupt(lnk.interrupt),
        .power_button_out_n(lnk.power_button_out_n), .adapter_present(lnk.adapter_present));

    // 25 MHz system clock.
    initial begin
        forever #20 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // Bounded wait for a state; a hang is counted and ends the run.
    task automatic wait_state(input psh_pkg::psh_state_t s);
        int i;
        for (i = 0; i < 300 && power_state !== s; i++) @(negedge mclk);
        if (power_state !== s) begin
            bad_count++;
            $display("CHECK FAILED t=%0t timeout state %h exp %h", $time, power_state, s);
            conclude();
        end
    endtask : wait_state

    // Brings the rails up from power-down and checks the handshake outputs.
    task automatic power_up();
        @(posedge mclk) power_on_request <= 1'b1;
        wait_state(psh_pkg::PSH_AON_UP);
        `CHK({always_on_3v3_rail_en, lnk.resume_reset_n}, 2'h2);
        wait_state(psh_pkg::PSH_ACTIVE);
        cyc(4);
        @(negedge mclk);
        `CHK(lnk.resume_reset_n, 1'b1);
        `CHK(lnk.memory_power_good, 1'b1);
        `CHK({lnk.always_on_power_good, lnk.core_power_good}, 2'h3);
        `CHK(device_ready, 1'b1);
        $display("test power_up done");
    endtask : power_up

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {power_button_in_n, always_on_3v3_rail_good, memory_supply_rail_good} = 3'h7;
        {core_rails_good, adapter_voltage_valid, battery_voltage_low} = 3'h4;
        {power_on_request, req_standby_idle, req_suspend_ram, req_suspend_disk} = 4'h0;
        {req_powerdown, platform_in_reset, thermal_event, sd_1v8_wanted, charger_seen} = 5'h0;
        {irq_events, irq_mask, irq_clear} = 24'h0;
        cyc(20);
        rst_n <= 1'b1;
        @(negedge mclk);
        `CHK({lnk.resume_reset_n, lnk.core_power_good}, 2'h0);
        `CHK(lnk.power_button_out_n, 1'b1);
        power_up();
        // Bouncing contacts never stay still for the debounce time.
        repeat (300) begin
            r = $random(seed);
            @(posedge mclk) power_button_in_n <= r[0];
            @(negedge mclk);
            `CHK({lnk.power_button_out_n, button_pressed}, 2'h2);
        end
        @(posedge mclk) power_button_in_n <= 1'b1;
        $display("test bounce done");
        // Random levels on the select and presence lines.
        repeat (16) begin
            r = $random(seed);
            @(posedge mclk) {sd_1v8_wanted, charger_seen} <= r[1:0];
            {adapter_voltage_valid, battery_voltage_low} <= r[3:2];
            cyc(8);
            @(negedge mclk);
            `CHK(sd_supply_1v8_sel, r[1]);
            `CHK(lnk.adapter_present, r[0] | r[3]);
            `CHK(lnk.battery_low_n, !r[2]);
        end
        $display("test side_lines done");
        // Every interrupt source, each under a random mask.
        for (int b = 0; b < psh_pkg::IRQ_W; b++) begin
            r = $random(seed);
            exp_irq = !r[b];
            @(posedge mclk) irq_mask <= r[psh_pkg::IRQ_W-1:0];
            irq_events <= 8'h1 << b;
            @(posedge mclk) irq_events <= 8'h0;
            cyc(4);
            @(negedge mclk);
            `CHK(irq_status[b], 1'b1);
            `CHK(lnk.interrupt, exp_irq);
            `CHK(interrupt_seen, exp_irq);
            @(posedge mclk) irq_clear <= 8'h1 << b;
            @(posedge mclk) irq_clear <= 8'h0;
            cyc(4);
            @(negedge mclk);
            `CHK(lnk.interrupt, 1'b0);
        end
        $display("test irq done");
        // Standby entry with both lows, then platform reset ignored.
        @(posedge mclk) {req_standby_idle, platform_in_reset} <= 2'h3;
        wait_state(psh_pkg::PSH_STANDBY_IDLE);
        cyc(4);
        @(negedge mclk);
        `CHK({lnk.always_on_power_good, lnk.core_power_good}, 2'h0);
        @(posedge mclk) platform_in_reset <= 1'b0;
        cyc(10);
        @(negedge mclk);
        `CHK(power_state, psh_pkg::PSH_STANDBY_IDLE);
        @(posedge mclk) req_standby_idle <= 1'b0;
        wait_state(psh_pkg::PSH_ACTIVE);
        $display("test standby done");
        @(posedge mclk) req_suspend_ram <= 1'b1;
        wait_state(psh_pkg::PSH_SUSPEND_RAM);
        @(posedge mclk) req_suspend_ram <= 1'b0;
        wait_state(psh_pkg::PSH_ACTIVE);
        cyc(4);
        $display("test suspend_ram done");
        // A trip while the platform is held in reset is not sampled.
        @(posedge mclk) {platform_in_reset, thermal_event} <= 2'h3;
        cyc(12);
        @(negedge mclk);
        `CHK({thermal_shutdown, power_state}, {1'b0, psh_pkg::PSH_ACTIVE});
        @(posedge mclk) thermal_event <= 1'b0;
        cyc(6);
        @(posedge mclk) platform_in_reset <= 1'b0;
        cyc(6);
        @(posedge mclk) thermal_event <= 1'b1;
        wait_state(psh_pkg::PSH_POWER_DOWN);
        cyc(2);
        @(negedge mclk);
        `CHK({thermal_shutdown, always_on_3v3_rail_en, suspend_rails_en}, 5'h10);
        `CHK({memory_supply_rail_en, core_rails_en, lnk.resume_reset_n}, 3'h0);
        @(posedge mclk) {thermal_event, power_on_request} <= 2'h0;
        cyc(4);
        $display("test thermal done");
        power_up();
        @(posedge mclk) req_suspend_disk <= 1'b1;
        wait_state(psh_pkg::PSH_SUSPEND_DISK);
        @(posedge mclk) req_suspend_disk <= 1'b0;
        wait_state(psh_pkg::PSH_ACTIVE);
        @(posedge mclk) req_suspend_disk <= 1'b1;
        wait_state(psh_pkg::PSH_SUSPEND_DISK);
        @(posedge mclk) {power_on_request, req_powerdown} <= 2'h1;
        wait_state(psh_pkg::PSH_POWER_DOWN);
        cyc(3);
        @(negedge mclk);
        `CHK(suspend_rails_en, 3'h0);
        `CHK({lnk.resume_reset_n, lnk.core_power_good}, 2'h0);
        $display("test suspend_disk done");
        conclude();
    end
endmodule : soc_power_state_handshake_tb_top
`default_nettype wire
